// ==== rtl/pucs_top.sv ====
`timescale 1ns/10ps
module pucs_top import pucs_pkg::*; #(
    parameter int unsigned SETTLE_CYCLES    = SETTLE_CYC,      // 10 ms quiet time
    parameter int unsigned LOAD_HOLD_CYCLES = LOAD_HOLD_CYC,   // 1 ms after a change
    parameter int unsigned SYNC_RST_CYCLES  = SYNC_RST_CYC,    // divider sync reset length
    parameter int unsigned WORDS            = WORDS_PER_SET,   // words per set
    parameter logic [NUM_SETS*WORDS*WORD_W-1:0] OTP_IMAGE = '0 // factory contents
) (
    input  logic                      clk_sys,
    input  logic                      nrst,
    // strap pin, later the reference clock
    input  logic                      strap_mode_pin_in,
    output logic                      strap_mode_pin_out,
    output logic                      strap_mode_pin_oe,
    input  logic                      ref_clk_level,
    // shared pin pair: selects or serial data/clock
    input  logic                      config_select_upper_in,
    output logic                      config_select_upper_out,
    output logic                      config_select_upper_oe,
    input  logic                      config_select_lower_in,
    // serial core side
    output logic                      i2c_enable,
    output logic                      i2c_addr_ack_en,
    output logic                      i2c_sda_rx,
    output logic                      i2c_scl_rx,
    input  logic                      i2c_sda_pull_low,
    input  logic                      otp_prog_req,
    input  logic [$clog2(NUM_SETS*WORDS)-1:0] otp_prog_addr,
    input  logic [WORD_W-1:0]         otp_prog_data,
    // sync reset mask, configuration outputs
    input  logic                      sync_rst_disable,
    output logic                      div_sync_rst,
    output logic [WORDS*WORD_W-1:0]   work_regs,
    output logic [SEL_W:0]            active_config,
    output logic                      config_ready
);

    localparam int unsigned WD_W = $clog2(WORDS);
    localparam int unsigned AW   = $clog2(NUM_SETS * WORDS);
    localparam logic [WD_W-1:0] LAST_WORD = WD_W'(WORDS - 1);

    // synchronised pins
    logic [SEL_W-1:0]       pin_sync;      // {upper, lower}
    logic                   strap_sync;    // strap pin, safe level

    // sequencer state
    pucs_state_type         st_q, st_d;
    logic [TMR_W-1:0]       tmr_q, tmr_d;      // shared wait timer
    logic                   strap_q, strap_d;  // captured mode, 1 = hardware select
    logic                   first_q, first_d;  // first load pending
    logic [SEL_W-1:0]       sel_q, sel_d;      // set now active
    logic                   dflt_q, dflt_d;    // use host defaults
    logic [WD_W-1:0]        wd_q, wd_d;        // word being read

    // load datapath
    logic                   rd_vld_q, rd_vld_d;   // read data arrive this cycle
    logic [WD_W-1:0]        wr_wd_q, wr_wd_d;     // where they go
    logic [WORDS*WORD_W-1:0] work_q, work_d;      // working registers
    logic [AW-1:0]          rd_addr;
    logic [WORD_W-1:0]      rd_data;
    logic                   host_flag;            // stored default flag

    // status and pins
    logic                   ready_q, ready_d;
    logic                   ack_q, ack_d;
    logic                   i2c_en_q, i2c_en_d;
    logic                   sda_rx_q, sda_rx_d;
    logic                   scl_rx_q, scl_rx_d;
    logic                   strap_out_q, strap_out_d;
    logic                   strap_oe_q, strap_oe_d;
    logic                   up_out_q, up_out_d;
    logic                   up_oe_q, up_oe_d;
    logic [SEL_W:0]         act_q, act_d;

    // divider sync reset
    logic [TMR_W-1:0]       srst_cnt_q, srst_cnt_d;
    logic                   srst_q, srst_d;

    // decoded conditions
    logic                   load_end;     // last word issued this cycle
    logic                   change_ok;    // select changes are honoured

    // outside pins pass two flops first
    pucs_sync2 #(
        .W        (SEL_W)
    ) u_sel_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in ({config_select_upper_in, config_select_lower_in}),
        .sync_out (pin_sync)
    );

    pucs_sync2 #(
        .W        (1)
    ) u_strap_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in (strap_mode_pin_in),
        .sync_out (strap_sync)
    );

    // stored sets, burnt from the host side once ready
    pucs_otp #(
        .WORDS       (WORDS),
        .AW          (AW),
        .IMAGE       (OTP_IMAGE)
    ) u_otp (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .rd_addr     (rd_addr),
        .rd_data_q   (rd_data),
        .host_flag_q (host_flag),
        .prog_req    (otp_prog_req & i2c_en_q & ready_q),
        .prog_addr   (otp_prog_addr),
        .prog_data   (otp_prog_data)
    );

    assign load_end  = (st_q == ST_LOAD) && (wd_q == LAST_WORD);
    // only hardware mode with the flag clear follows the pins
    assign change_ok = (strap_q == STRAP_HW_SELECT) && !host_flag;
    assign rd_addr   = {sel_q, wd_q};

    // sequencer next state
    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q;
        strap_d = strap_q;
        first_d = first_q;
        sel_d   = sel_q;
        dflt_d  = dflt_q;
        wd_d    = wd_q;
        unique case (st_q)
            ST_CAPTURE: begin
                // let the synchroniser fill, then sample once
                if (tmr_q == TMR_W'(STRAP_WAIT_CYC - 1)) begin
                    strap_d = strap_sync;
                    if (strap_sync == STRAP_HW_SELECT) begin
                        sel_d  = pin_sync;
                        dflt_d = 1'b0;
                    end else begin
                        sel_d  = '0;
                        dflt_d = host_flag;
                    end
                    tmr_d = '0;
                    wd_d  = '0;
                    st_d  = ST_LOAD;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            ST_LOAD: begin
                // one read issued per cycle
                if (wd_q == LAST_WORD) begin
                    tmr_d   = '0;
                    first_d = 1'b0;
                    if (!first_q) begin
                        st_d = ST_HOLD;
                    end else if (change_ok) begin
                        st_d = ST_SETTLE;
                    end else begin
                        st_d = ST_RUN;
                    end
                end else begin
                    wd_d = wd_q + 1'b1;
                end
            end
            ST_SETTLE: begin
                // pins ignored in the start-up quiet time
                if (tmr_q == TMR_W'(SETTLE_CYCLES - 1)) begin
                    tmr_d = '0;
                    st_d  = ST_RUN;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            ST_RUN: begin
                // compare synced pins with the active set
                if (change_ok && (pin_sync != sel_q)) begin
                    sel_d = pin_sync;
                    wd_d  = '0;
                    st_d  = ST_LOAD;
                end
            end
            ST_HOLD: begin
                // a move inside the hold waits for RUN
                if (tmr_q == TMR_W'(LOAD_HOLD_CYCLES - 1)) begin
                    tmr_d = '0;
                    st_d  = ST_RUN;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                // illegal code: restart power-up
                tmr_d = '0;
                st_d  = ST_CAPTURE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q    <= ST_CAPTURE;
            tmr_q   <= '0;
            strap_q <= 1'b0;
            first_q <= 1'b1;
            sel_q   <= '0;
            dflt_q  <= 1'b0;
            wd_q    <= '0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            strap_q <= strap_d;
            first_q <= first_d;
            sel_q   <= sel_d;
            dflt_q  <= dflt_d;
            wd_q    <= wd_d;
        end
    end

    // load datapath: data land a cycle after the read
    always_comb begin
        rd_vld_d = (st_q == ST_LOAD);
        wr_wd_d  = wd_q;
        work_d   = work_q;
        if (rd_vld_q) begin
            // host defaults replace stored words
            work_d[wr_wd_q*WORD_W +: WORD_W] = dflt_q ? HOST_DEFAULT_WORD : rd_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_vld_q <= 1'b0;
            wr_wd_q  <= '0;
            work_q   <= '0;
        end else begin
            rd_vld_q <= rd_vld_d;
            wr_wd_q  <= wr_wd_d;
            work_q   <= work_d;
        end
    end

    // status and pin steering
    always_comb begin
        // ready once the last word has landed
        ready_d     = (st_q != ST_CAPTURE) && (st_q != ST_LOAD);
        i2c_en_d    = (st_q != ST_CAPTURE) && (strap_q != STRAP_HW_SELECT);
        ack_d       = ready_d && i2c_en_d;
        sda_rx_d    = i2c_en_d ? pin_sync[1] : 1'b1;
        scl_rx_d    = i2c_en_d ? pin_sync[0] : 1'b1;
        // only pull low; the bus is open-drain
        up_out_d    = 1'b0;
        up_oe_d     = i2c_en_d && i2c_sda_pull_low;
        strap_oe_d  = (st_q != ST_CAPTURE);
        strap_out_d = strap_oe_d && ref_clk_level;
        act_d       = {dflt_q, sel_q};
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ready_q     <= 1'b0;
            i2c_en_q    <= 1'b0;
            ack_q       <= 1'b0;
            sda_rx_q    <= 1'b1;
            scl_rx_q    <= 1'b1;
            up_out_q    <= 1'b0;
            up_oe_q     <= 1'b0;
            strap_oe_q  <= 1'b0;
            strap_out_q <= 1'b0;
            act_q       <= '0;
        end else begin
            ready_q     <= ready_d;
            i2c_en_q    <= i2c_en_d;
            ack_q       <= ack_d;
            sda_rx_q    <= sda_rx_d;
            scl_rx_q    <= scl_rx_d;
            up_out_q    <= up_out_d;
            up_oe_q     <= up_oe_d;
            strap_oe_q  <= strap_oe_d;
            strap_out_q <= strap_out_d;
            act_q       <= act_d;
        end
    end

    // divider sync reset: always at power-up, maskable later
    always_comb begin
        srst_cnt_d = srst_cnt_q;
        if (load_end && (first_q || !sync_rst_disable)) begin
            srst_cnt_d = TMR_W'(SYNC_RST_CYCLES);
        end else if (srst_cnt_q != '0) begin
            srst_cnt_d = srst_cnt_q - 1'b1;
        end
        srst_d = (srst_cnt_d != '0);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            srst_cnt_q <= '0;
            srst_q     <= 1'b0;
        end else begin
            srst_cnt_q <= srst_cnt_d;
            srst_q     <= srst_d;
        end
    end

    // every output straight from a flop
    assign strap_mode_pin_out      = strap_out_q;
    assign strap_mode_pin_oe       = strap_oe_q;
    assign config_select_upper_out = up_out_q;
    assign config_select_upper_oe  = up_oe_q;
    assign i2c_enable              = i2c_en_q;
    assign i2c_addr_ack_en         = ack_q;
    assign i2c_sda_rx              = sda_rx_q;
    assign i2c_scl_rx              = scl_rx_q;
    assign div_sync_rst            = srst_q;
    assign work_regs               = work_q;
    assign active_config           = act_q;
    assign config_ready            = ready_q;

endmodule

// ==== rtl/pucs_pkg.sv ====
package pucs_pkg;

    // clock and derived timing
    localparam int unsigned CLK_HZ          = 25_000_000;     // clk_sys rate
    localparam int unsigned STRAP_WAIT_CYC  = 4;              // sync fill before capture
    localparam int unsigned SETTLE_MS       = 10;             // quiet before select changes
    localparam int unsigned SETTLE_CYC      = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int unsigned LOAD_HOLD_MS    = 1;              // hold after a select change
    localparam int unsigned LOAD_HOLD_CYC   = (CLK_HZ / 1000) * LOAD_HOLD_MS;
    localparam int unsigned SYNC_RST_US     = 300;            // divider sync reset length
    localparam int unsigned SYNC_RST_CYC    = (CLK_HZ / 1_000_000) * SYNC_RST_US;
    localparam int unsigned TMR_W           = 20;             // fits every count

    // storage layout
    localparam int unsigned NUM_SETS        = 4;              // selectable stored sets
    localparam int unsigned SEL_W           = 2;              // select index width
    localparam int unsigned WORDS_PER_SET   = 8;              // words loaded per set
    localparam int unsigned WORD_W          = 8;              // bits per word
    localparam int unsigned FLAG_WORD       = 0;              // word of the default flag
    localparam int unsigned FLAG_BIT        = 7;              // bit of that word
    localparam logic [WORD_W-1:0] HOST_DEFAULT_WORD = 8'h00;  // host default contents

    // strap meaning
    localparam logic STRAP_HW_SELECT = 1'b1;                  // pull-up: hardware selection

    // sequencer states, gray along capture, load, settle, run, hold
    typedef enum logic [2:0] {
        ST_CAPTURE = 3'h0,
        ST_LOAD    = 3'h1,
        ST_SETTLE  = 3'h3,
        ST_RUN     = 3'h2,
        ST_HOLD    = 3'h6
    } pucs_state_type;

endpackage

// ==== rtl/pucs_sync2.sv ====
`timescale 1ns/10ps
module pucs_sync2 #(
    parameter int unsigned W = 1
) (
    input  logic         clk_sys,
    input  logic         nrst,
    input  logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;   // first stage, read only by the second
    logic [W-1:0] sync_q;   // second stage, safe to use

    // two flops per bit, reset to a constant
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ==== rtl/pucs_otp.sv ====
`timescale 1ns/10ps
module pucs_otp import pucs_pkg::*; #(
    parameter int unsigned            WORDS = WORDS_PER_SET,
    parameter int unsigned            AW    = $clog2(NUM_SETS * WORDS),
    parameter logic [NUM_SETS*WORDS*WORD_W-1:0] IMAGE = '0
) (
    input  logic              clk_sys,
    input  logic              nrst,
    input  logic [AW-1:0]     rd_addr,
    output logic [WORD_W-1:0] rd_data_q,
    output logic              host_flag_q,
    input  logic              prog_req,
    input  logic [AW-1:0]     prog_addr,
    input  logic [WORD_W-1:0] prog_data
);

    localparam int unsigned DEPTH = NUM_SETS * WORDS;

    logic [WORD_W-1:0] mem [DEPTH];   // four sets back to back
    logic [WORD_W-1:0] rd_data_d;
    logic              host_flag_d;

    // factory image; no reset touches the array
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = IMAGE[i*WORD_W +: WORD_W];
        end
    end

    // programming only sets bits, like a fuse
    always_ff @(posedge clk_sys) begin
        if (prog_req) begin
            mem[prog_addr] <= mem[prog_addr] | prog_data;
        end
    end

    // read port and flag view
    always_comb begin
        rd_data_d   = mem[rd_addr];
        host_flag_d = mem[FLAG_WORD][FLAG_BIT];
    end

    // read data come out of registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data_q   <= '0;
            host_flag_q <= 1'b0;
        end else begin
            rd_data_q   <= rd_data_d;
            host_flag_q <= host_flag_d;
        end
    end

endmodule

// ==== tb/pucs_chk.sv ====
`timescale 1ns/10ps
module pucs_chk import pucs_pkg::*; #(
    parameter int unsigned SYNC_RST_CYCLES  = SYNC_RST_CYC,
    parameter int unsigned LOAD_HOLD_CYCLES = LOAD_HOLD_CYC,
    parameter int unsigned WORDS            = WORDS_PER_SET
) (
    input wire logic                    clk_sys,
    input wire logic                    nrst,
    input wire logic                    strap_mode_pin_out,
    input wire logic                    strap_mode_pin_oe,
    input wire logic                    ref_clk_level,
    input wire logic                    config_select_upper_out,
    input wire logic                    config_select_upper_oe,
    input wire logic                    i2c_enable,
    input wire logic                    i2c_addr_ack_en,
    input wire logic                    i2c_sda_rx,
    input wire logic                    i2c_scl_rx,
    input wire logic                    i2c_sda_pull_low,
    input wire logic                    sync_rst_disable,
    input wire logic                    div_sync_rst,
    input wire logic [WORDS*WORD_W-1:0] work_regs,
    input wire logic [SEL_W:0]          active_config,
    input wire logic                    config_ready
);
    logic [TMR_W-1:0] pulse_q, pulse_d; // sync reset run length
    logic [TMR_W-1:0] quiet_q, quiet_d; // cycles ready has stood

    // run-length counters
    always_comb begin
        pulse_d = div_sync_rst ? pulse_q + 1'b1 : '0;
        quiet_d = config_ready ? quiet_q + 1'b1 : '0;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= '0;
            quiet_q <= '0;
        end else begin
            pulse_q <= pulse_d;
            quiet_q <= quiet_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // reload: ready drops, then returns
    sequence reload_s;
        $fell(config_ready);
    endsequence
    sequence load_done_s;
        ##[8:12] config_ready;
    endsequence

    strap_drive_a: assert property (strap_mode_pin_oe |=> strap_mode_pin_oe)
        else $error("strap enable dropped");
    ref_forward_a: assert property (strap_mode_pin_oe && $past(strap_mode_pin_oe)
        |-> strap_mode_pin_out == $past(ref_clk_level))
        else $error("reference not forwarded");
    capture_quiet_a: assert property (!strap_mode_pin_oe |-> !strap_mode_pin_out && !i2c_enable)
        else $error("activity before strap capture");
    sda_pull_a: assert property (config_select_upper_oe
        == (i2c_enable && $past(i2c_sda_pull_low)) && !config_select_upper_out)
        else $error("data line pull wrong");
    rx_idle_a: assert property (!i2c_enable |-> i2c_sda_rx && i2c_scl_rx)
        else $error("receive active outside host mode");
    ack_ready_a: assert property (i2c_addr_ack_en |-> i2c_enable && config_ready)
        else $error("acknowledge before ready");
    host_fixed_a: assert property (i2c_enable && config_ready
        |=> $stable(active_config) && config_ready)
        else $error("host configuration moved");
    regs_steady_a: assert property (config_ready && $past(config_ready) |-> $stable(work_regs))
        else $error("work registers moved while ready");
    load_len_a: assert property (reload_s |-> load_done_s)
        else $error("reload length wrong");
    sync_len_a: assert property ($fell(div_sync_rst) |-> pulse_q == SYNC_RST_CYCLES)
        else $error("sync reset length wrong");
    sync_start_a: assert property ($rose(config_ready) && !sync_rst_disable
        |-> ##[0:1] div_sync_rst)
        else $error("sync reset missing after load");
    hold_gap_a: assert property (reload_s |-> quiet_q >= LOAD_HOLD_CYCLES)
        else $error("reload inside hold time");
endmodule

bind pucs_top pucs_chk #(
    .SYNC_RST_CYCLES (SYNC_RST_CYCLES),
    .LOAD_HOLD_CYCLES(LOAD_HOLD_CYCLES),
    .WORDS           (WORDS)
) chk_u (.clk_sys, .nrst, .strap_mode_pin_out, .strap_mode_pin_oe, .ref_clk_level,
    .config_select_upper_out, .config_select_upper_oe, .i2c_enable, .i2c_addr_ack_en,
    .i2c_sda_rx, .i2c_scl_rx, .i2c_sda_pull_low, .sync_rst_disable, .div_sync_rst,
    .work_regs, .active_config, .config_ready);

// ==== tb/pucs_board.sv ====
`timescale 1ns/10ps
module pucs_board #(
    parameter int unsigned GAP = 40 // quiet cycles per move
) (
    input  wire logic       clk_sys,
    input  wire logic       strap_pull,   // strap resistor level
    input  wire logic       preset,       // pins follow target at once
    input  wire logic [1:0] sel_target,   // wanted select levels
    input  wire logic       strap_mode_pin_out,
    input  wire logic       strap_mode_pin_oe,
    input  wire logic       config_select_upper_out,
    input  wire logic       config_select_upper_oe,
    output logic            strap_mode_pin_in,
    output logic            config_select_upper_in,
    output logic            config_select_lower_in
);
    logic [1:0] sel_q = 2'h0; // host output levels
    int         gap_q = 0;    // cycles since last move

    // device drive when enabled, else board level
    assign strap_mode_pin_in      = strap_mode_pin_oe ? strap_mode_pin_out : strap_pull;
    assign config_select_upper_in = config_select_upper_oe ? config_select_upper_out
                                                           : sel_q[1];
    assign config_select_lower_in = sel_q[0];

    // one pin per step, lower bit first
    always @(posedge clk_sys) begin
        if (preset) begin
            sel_q <= sel_target;
            gap_q <= 0;
        end else if (sel_q != sel_target && gap_q >= GAP) begin
            if (sel_q[0] != sel_target[0])
                sel_q[0] <= sel_target[0];
            else
                sel_q[1] <= sel_target[1];
            gap_q <= 0;
        end else begin
            gap_q <= gap_q + 1;
        end
    end
endmodule

// ==== tb/pucs_top_tb.sv ====
`timescale 1ns/10ps
module pucs_top_tb import pucs_pkg::*;;
    localparam int RW = WORDS_PER_SET * WORD_W; // working width
    localparam int SR = 10;                     // shortened sync reset
    localparam int TMO_CYC = 3000;              // run needs ~800

    // set s word w holds 8s+w+1, so the flag bit stays clear
    function automatic logic [RW-1:0] exp_regs(input int s);
        logic [RW-1:0] r;
        for (int w = 0; w < WORDS_PER_SET; w++) r[WORD_W*w +: WORD_W] = WORD_W'(s * 8 + w + 1);
        return r;
    endfunction

    logic          clk_sys = 1'b0, nrst = 1'b0, strap_pull = 1'b1, preset = 1'b1;
    logic [1:0]    sel_target = 2'h0;
    logic          ref_clk_level = 1'b0, i2c_sda_pull_low = 1'b0, sync_rst_disable = 1'b0;
    logic          otp_prog_req = 1'b0;
    logic [4:0]    otp_prog_addr = 5'h00;
    logic [7:0]    otp_prog_data = 8'h00;
    logic          strap_mode_pin_in, strap_mode_pin_out, strap_mode_pin_oe;
    logic          config_select_upper_in, config_select_upper_out, config_select_upper_oe;
    logic          config_select_lower_in, i2c_enable, i2c_addr_ack_en, i2c_sda_rx, i2c_scl_rx;
    logic          div_sync_rst, config_ready;
    logic [RW-1:0] work_regs;
    logic [2:0]    active_config;
    int            n_errors = 0, num_checks = 0, tmo_q = 0;

    pucs_top #(.SETTLE_CYCLES(50), .LOAD_HOLD_CYCLES(20), .SYNC_RST_CYCLES(SR),
        .WORDS(WORDS_PER_SET), .OTP_IMAGE({exp_regs(3), exp_regs(2), exp_regs(1), exp_regs(0)}))
        dut_u (.clk_sys, .nrst,
        .strap_mode_pin_in, .strap_mode_pin_out, .strap_mode_pin_oe, .ref_clk_level,
        .config_select_upper_in, .config_select_upper_out, .config_select_upper_oe,
        .config_select_lower_in, .i2c_enable, .i2c_addr_ack_en, .i2c_sda_rx, .i2c_scl_rx,
        .i2c_sda_pull_low, .otp_prog_req, .otp_prog_addr, .otp_prog_data, .sync_rst_disable,
        .div_sync_rst, .work_regs, .active_config, .config_ready);

    pucs_board #(.GAP(40)) board_u (.clk_sys, .strap_pull, .preset, .sel_target,
        .strap_mode_pin_out, .strap_mode_pin_oe, .config_select_upper_out,
        .config_select_upper_oe, .strap_mode_pin_in, .config_select_upper_in,
        .config_select_lower_in);

    // clock and reference level
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) ref_clk_level <= #1 ~ref_clk_level;

    // cut a hang short
    always @(posedge clk_sys) begin
        tmo_q <= tmo_q + 1;
        if (tmo_q == TMO_CYC) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [RW-1:0] exp, input logic [RW-1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // straps held through reset and capture, then freed
    task automatic power_up(input logic strap, input logic [1:0] sel);
        int n;
        cyc(1);
        nrst = 1'b0;
        preset = 1'b1;
        strap_pull = strap;
        sel_target = sel;
        cyc(20);
        nrst = 1'b1;
        n = 0;
        while (config_ready !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk_bit("config_ready", 1'b1, config_ready);
        preset = 1'b0;
    endtask

    task automatic hw_boot(input logic [1:0] sel);
        power_up(1'b1, sel);
        chk_bit("i2c_enable", 1'b0, i2c_enable);
        chk_bit("strap_oe", 1'b1, strap_mode_pin_oe);
        chk_vec("active_config", RW'({1'b0, sel}), RW'(active_config));
        chk_vec("work_regs", exp_regs(int'(sel)), work_regs);
    endtask

    // early move held until the quiet time ends, later moves one pin at a time
    task automatic hw_switch();
        int hi, hit;
        power_up(1'b1, 2'h0);
        sel_target = 2'h1;
        cyc(45);
        chk_vec("active_config", RW'(3'h0), RW'(active_config));
        hi = 0;
        repeat (60) begin
            cyc(1);
            if (div_sync_rst === 1'b1) hi++;
        end
        chk_vec("active_config", RW'(3'h1), RW'(active_config));
        chk_vec("work_regs", exp_regs(1), work_regs);
        chk_vec("sync_pulse", RW'(SR), RW'(hi));
        sync_rst_disable = 1'b1;
        sel_target = 2'h2;
        hit = 0;
        repeat (120) begin
            cyc(1);
            if (div_sync_rst !== 1'b0) hit = 1;
        end
        chk_vec("active_config", RW'(3'h2), RW'(active_config));
        chk_vec("work_regs", exp_regs(2), work_regs);
        chk_bit("sync_suppressed", 1'b0, 1'(hit));
        sync_rst_disable = 1'b0;
    endtask

    // host mode: pins to serial core, flag burnt
    task automatic host_mode();
        power_up(1'b0, 2'h3);
        chk_bit("i2c_enable", 1'b1, i2c_enable);
        chk_bit("ack_en", 1'b1, i2c_addr_ack_en);
        chk_vec("active_config", RW'(3'h0), RW'(active_config));
        chk_vec("work_regs", exp_regs(0), work_regs);
        sel_target = 2'h0;
        cyc(100);
        chk_vec("active_config", RW'(3'h0), RW'(active_config));
        chk_bit("scl_rx", 1'b0, i2c_scl_rx);
        chk_bit("sda_rx", 1'b0, i2c_sda_rx);
        sel_target = 2'h3;
        cyc(90);
        chk_bit("sda_rx", 1'b1, i2c_sda_rx);
        i2c_sda_pull_low = 1'b1;
        cyc(5);
        chk_bit("sda_oe", 1'b1, config_select_upper_oe);
        chk_bit("sda_rx", 1'b0, i2c_sda_rx);
        i2c_sda_pull_low = 1'b0;
        otp_prog_data = 8'h80;
        otp_prog_req = 1'b1;
        cyc(1);
        otp_prog_req = 1'b0;
    endtask

    // flag set: host defaults, or frozen pins
    task automatic host_default();
        power_up(1'b0, 2'h0);
        chk_vec("active_config", RW'(3'h4), RW'(active_config));
        chk_vec("work_regs", {WORDS_PER_SET{HOST_DEFAULT_WORD}}, work_regs);
        power_up(1'b1, 2'h2);
        chk_vec("active_config", RW'(3'h2), RW'(active_config));
        sel_target = 2'h3;
        cyc(100);
        chk_vec("active_config", RW'(3'h2), RW'(active_config));
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        for (int s = 0; s < 4; s++) hw_boot(2'(s));
        hw_switch();
        host_mode();
        host_default();
        give_verdict();
    end
endmodule
